// File: rtl/tch_defs.svh
// register offsets, field positions and reset values of the timer channel block
`ifndef TCH_DEFS_SVH
`define TCH_DEFS_SVH
`define TCH_ADR_TSC 8'h00
`define TCH_ADR_CNTH 8'h04
`define TCH_ADR_CNTL 8'h08
`define TCH_ADR_MODH 8'h0C
`define TCH_ADR_MODL 8'h10
`define TCH_ADR_CH_BASE 8'h14
`define TCH_ADR_CH_STRIDE 8'h0C
`define TCH_OFS_CSC 8'h00
`define TCH_OFS_VH 8'h04
`define TCH_OFS_VL 8'h08
`define TCH_BIT_FLAG 7
`define TCH_BIT_IE 6
`define TCH_BIT_CENTER_ALIGN_SELECT 5
`define TCH_BIT_MSH 5
`define TCH_BIT_MSL 4
`define TCH_BIT_ELSH 3
`define TCH_BIT_ELSL 2
`define TCH_RST_BYTE 8'h00
`define TCH_RST_WORD 16'h0000
`define TCH_CNT_MAX 16'hFFFF
`define TCH_ONE 16'h0001
`endif

// File: rtl/tch_pkg.sv
// types shared by the timer channel block
package tch_pkg;
    // channel control byte, bits 1:0 unused
    typedef struct packed {
        logic ie;
        logic msh;
        logic msl;
        logic elsh;
        logic elsl;
    } tch_chctl_t;
    // timer status control fields below the flag
    typedef struct packed {
        logic overflow_irq_enable;
        logic center_align_select;
        logic [1:0] clks;
        logic [2:0] ps;
    } tch_tsc_t;
    // per channel working mode
    typedef enum logic [1:0] {
        TCH_CAPTURE,
        TCH_COMPARE,
        TCH_EDGE_PWM,
        TCH_CENTER_PWM
    } tch_mode_t;
endpackage

// File: rtl/tch_timer.sv
// timer counter with compare, capture and pwm channels on wishbone
// Operation
// - compare match sets, clears or toggles pin
// - compare bytes load once both written
// - compare match sets channel flag
// - edge pwm: up count, modulus period
// - edge pwm polarity from level select low
// - edge pwm zero gives 0, above gives 100
// - edge pwm value loads at counter zero
// - center mode counts up then down
// - center pwm zero or negative gives 0
// - center up match low, down match high
// - center buffers load at turnaround
// - pwm buffers update together each period; in edge pwm the modulus loads as soon as both bytes are written
// - status write drops pending modulus bytes
// - channel status write drops pending bytes
// - flags gate level interrupts by enable
// - flag clears on read then write zero
// - up count flag on wrap to zero
// - up down flag at modulus turnaround
// - capture edge select sets channel flag
// - edge pwm flag on value match
// - center pwm flag on both matches
// - mode bits choose capture, compare, pwm
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`include "tch_defs.svh"
module tch_timer #(
    parameter int NCH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NCH-1:0] ch_pin_i,
    output logic [NCH-1:0] ch_pin_o,
    output logic [NCH-1:0] ch_oe_o,
    output logic ovf_irq_o,
    output logic [NCH-1:0] ch_irq_o
);
    // bus access taken on the edge that raises ack
    logic req;
    logic wr;
    logic rd;
    logic [7:0] wbyte;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd = req & ~wb_we_i;
    assign wbyte = wb_dat_i[7:0];

    tch_pkg::tch_tsc_t tsc_q; // timer status control fields
    logic tof_q; // overflow flag
    logic tof_arm_q; // flag seen set by a read
    logic [15:0] cnt_q; // main counter
    logic up_q; // count direction in center mode
    logic [15:0] mod_q; // active modulus
    logic [15:0] modb_q; // modulus byte buffer
    logic modh_ok_q; // high byte buffered
    logic modl_ok_q; // low byte buffered
    logic run;
    logic wrap; // up count wraps to zero
    logic turn; // center count turns at modulus
    logic cnt_wr;
    logic mod_go;

    // the timer clock selection is outside; any nonzero source runs it
    assign run = tsc_q.clks != 2'b00;
    assign cnt_wr = wr & (wb_adr_i == `TCH_ADR_CNTH
        || wb_adr_i == `TCH_ADR_CNTL);
    assign wrap = run & ~tsc_q.center_align_select & (cnt_q == `TCH_CNT_MAX
        || (mod_q != `TCH_RST_WORD && cnt_q == mod_q));
    assign turn = run & tsc_q.center_align_select & up_q & cnt_q == mod_q;
    // center mode defers the modulus to the turnaround
    assign mod_go = modh_ok_q & modl_ok_q & (~tsc_q.center_align_select | turn);

    // status control fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tsc_q <= '0;
        end else if (wr && wb_adr_i == `TCH_ADR_TSC) begin
            tsc_q <= tch_pkg::tch_tsc_t'(wbyte[6:0]);
        end
    end

    // overflow flag: event beats the clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tof_q <= 1'b0;
            tof_arm_q <= 1'b0;
        end else if (wrap | turn) begin
            tof_q <= 1'b1;
            tof_arm_q <= 1'b0;
        end else if (wr && wb_adr_i == `TCH_ADR_TSC) begin
            // writing one does nothing, zero clears only when armed
            if (!wbyte[`TCH_BIT_FLAG] && tof_arm_q) begin
                tof_q <= 1'b0;
            end
            tof_arm_q <= 1'b0;
        end else if (rd && wb_adr_i == `TCH_ADR_TSC && tof_q) begin
            tof_arm_q <= 1'b1;
        end
    end

    // main counter, cleared by any counter byte write
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_wr) begin
            cnt_q <= `TCH_RST_WORD;
            up_q <= 1'b1;
        end else if (!run) begin
            up_q <= up_q;
        end else if (!tsc_q.center_align_select) begin
            cnt_q <= wrap ? `TCH_RST_WORD : cnt_q + `TCH_ONE;
            up_q <= 1'b1;
        end else if (turn) begin
            cnt_q <= cnt_q - `TCH_ONE;
            up_q <= 1'b0;
        end else if (!up_q && cnt_q == `TCH_RST_WORD) begin
            cnt_q <= cnt_q + `TCH_ONE;
            up_q <= 1'b1;
        end else begin
            cnt_q <= up_q ? cnt_q + `TCH_ONE : cnt_q - `TCH_ONE;
        end
    end

    // modulus buffer; a status write drops half written bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mod_q <= `TCH_RST_WORD;
            modb_q <= `TCH_RST_WORD;
            modh_ok_q <= 1'b0;
            modl_ok_q <= 1'b0;
        end else if (wr && wb_adr_i == `TCH_ADR_TSC) begin
            modh_ok_q <= 1'b0;
            modl_ok_q <= 1'b0;
        end else if (wr && wb_adr_i == `TCH_ADR_MODH) begin
            modb_q[15:8] <= wbyte;
            modh_ok_q <= 1'b1;
        end else if (wr && wb_adr_i == `TCH_ADR_MODL) begin
            modb_q[7:0] <= wbyte;
            modl_ok_q <= 1'b1;
        end else if (mod_go) begin
            mod_q <= modb_q;
            modh_ok_q <= 1'b0;
            modl_ok_q <= 1'b0;
        end
    end

    // per channel state seen by the read mux
    tch_pkg::tch_chctl_t ctl_q [NCH];
    logic [NCH-1:0] flg_q;
    logic [15:0] val_q [NCH];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gch
            localparam logic [7:0] BASE = 8'(`TCH_ADR_CH_BASE
                + g * `TCH_ADR_CH_STRIDE);
            tch_pkg::tch_mode_t mode;
            logic csc_wr;
            logic vh_wr;
            logic vl_wr;
            logic arm_q; // flag seen set by a read
            logic [15:0] vb_q; // channel value byte buffer
            logic vh_ok_q;
            logic vl_ok_q;
            logic s1_q; // pin synchroniser, first stage
            logic s2_q;
            logic s3_q; // previous synchronised level
            logic hit; // counter equals channel value
            logic cap; // selected capture edge seen
            logic ev; // channel event this cycle
            logic act; // pwm active level intended
            logic ld;
            logic pos;

            assign csc_wr = wr && wb_adr_i == BASE + `TCH_OFS_CSC;
            assign vh_wr = wr && wb_adr_i == BASE + `TCH_OFS_VH;
            assign vl_wr = wr && wb_adr_i == BASE + `TCH_OFS_VL;
            assign hit = run & cnt_q == val_q[g];
            assign pos = val_q[g] != `TCH_RST_WORD & ~val_q[g][15];

            // center select overrides the channel mode bits
            always_comb begin
                if (tsc_q.center_align_select) begin
                    mode = tch_pkg::TCH_CENTER_PWM;
                end else if (ctl_q[g].msh) begin
                    mode = tch_pkg::TCH_EDGE_PWM;
                end else if (ctl_q[g].msl) begin
                    mode = tch_pkg::TCH_COMPARE;
                end else begin
                    mode = tch_pkg::TCH_CAPTURE;
                end
            end

            // capture edges: high select is rising, low is falling
            assign cap = (ctl_q[g].elsh & s2_q & ~s3_q)
                | (ctl_q[g].elsl & ~s2_q & s3_q);

            // each mode's event sets the channel flag
            always_comb begin
                case (mode)
                    tch_pkg::TCH_CAPTURE: ev = cap;
                    tch_pkg::TCH_COMPARE: ev = hit;
                    tch_pkg::TCH_EDGE_PWM: ev = hit;
                    tch_pkg::TCH_CENTER_PWM: ev = hit & pos;
                    default: ev = 1'b0;
                endcase
            end

            // when a fully written value moves to the active register
            always_comb begin
                case (mode)
                    tch_pkg::TCH_EDGE_PWM:
                        ld = cnt_q == `TCH_RST_WORD;
                    tch_pkg::TCH_CENTER_PWM: ld = turn;
                    default: ld = 1'b1;
                endcase
            end

            // pwm level before polarity; holds between matches
            always_comb begin
                act = ch_pin_o[g] ^ ctl_q[g].elsl;
                if (mode == tch_pkg::TCH_EDGE_PWM) begin
                    if (val_q[g] == `TCH_RST_WORD) begin
                        act = 1'b0;
                    end else if (hit) begin
                        act = 1'b0;
                    end else if (run && cnt_q == `TCH_RST_WORD) begin
                        act = 1'b1;
                    end
                end else begin
                    if (!pos) begin
                        act = 1'b0;
                    end else if (val_q[g] > mod_q) begin
                        act = 1'b1;
                    end else if (hit) begin
                        act = ~up_q;
                    end
                end
            end

            // two stage pin synchroniser and edge history
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= ch_pin_i[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            // channel control byte
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ctl_q[g] <= '0;
                end else if (csc_wr) begin
                    ctl_q[g] <= tch_pkg::tch_chctl_t'(wbyte[6:2]);
                end
            end

            // channel flag: event beats the clearing write
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    flg_q[g] <= 1'b0;
                    arm_q <= 1'b0;
                end else if (ev) begin
                    flg_q[g] <= 1'b1;
                    arm_q <= 1'b0;
                end else if (csc_wr) begin
                    if (!wbyte[`TCH_BIT_FLAG] && arm_q) begin
                        flg_q[g] <= 1'b0;
                    end
                    arm_q <= 1'b0;
                end else if (rd && wb_adr_i == BASE && flg_q[g]) begin
                    arm_q <= 1'b1;
                end
            end

            // value buffer, capture latch and coherency reset
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    val_q[g] <= `TCH_RST_WORD;
                    vb_q <= `TCH_RST_WORD;
                    vh_ok_q <= 1'b0;
                    vl_ok_q <= 1'b0;
                end else if (csc_wr) begin
                    vh_ok_q <= 1'b0;
                    vl_ok_q <= 1'b0;
                end else if (vh_wr) begin
                    vb_q[15:8] <= wbyte;
                    vh_ok_q <= 1'b1;
                end else if (vl_wr) begin
                    vb_q[7:0] <= wbyte;
                    vl_ok_q <= 1'b1;
                end else if (vh_ok_q && vl_ok_q && ld) begin
                    val_q[g] <= vb_q;
                    vh_ok_q <= 1'b0;
                    vl_ok_q <= 1'b0;
                end else if (mode == tch_pkg::TCH_CAPTURE && cap) begin
                    val_q[g] <= cnt_q;
                end
            end

            // pin drive per mode; level select zero frees the pin
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ch_pin_o[g] <= 1'b0;
                    ch_oe_o[g] <= 1'b0;
                end else begin
                    ch_oe_o[g] <= mode != tch_pkg::TCH_CAPTURE
                        && (ctl_q[g].elsh | ctl_q[g].elsl);
                    case (mode)
                        tch_pkg::TCH_COMPARE: begin
                            if (hit) begin
                                // 01 toggle, 10 clear, 11 set
                                case ({ctl_q[g].elsh, ctl_q[g].elsl})
                                    2'b01: ch_pin_o[g] <= ~ch_pin_o[g];
                                    2'b10: ch_pin_o[g] <= 1'b0;
                                    2'b11: ch_pin_o[g] <= 1'b1;
                                    default: ch_pin_o[g] <= ch_pin_o[g];
                                endcase
                            end
                        end
                        tch_pkg::TCH_CAPTURE: ch_pin_o[g] <= 1'b0;
                        default: ch_pin_o[g] <= act ^ ctl_q[g].elsl;
                    endcase
                end
            end

            // level interrupt while flag and enable are both set
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ch_irq_o[g] <= 1'b0;
                end else begin
                    ch_irq_o[g] <= flg_q[g] & ctl_q[g].ie;
                end
            end
        end
    endgenerate

    // overflow level interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_irq_o <= 1'b0;
        end else begin
            ovf_irq_o <= tof_q & tsc_q.overflow_irq_enable;
        end
    end

    // read mux; unmapped offsets read zero and still ack
    logic [7:0] rbyte;
    always_comb begin
        rbyte = `TCH_RST_BYTE;
        case (wb_adr_i)
            `TCH_ADR_TSC: rbyte = {tof_q, tsc_q};
            `TCH_ADR_CNTH: rbyte = cnt_q[15:8];
            `TCH_ADR_CNTL: rbyte = cnt_q[7:0];
            `TCH_ADR_MODH: rbyte = mod_q[15:8];
            `TCH_ADR_MODL: rbyte = mod_q[7:0];
            default: rbyte = `TCH_RST_BYTE;
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (wb_adr_i == 8'(`TCH_ADR_CH_BASE + i * `TCH_ADR_CH_STRIDE))
                rbyte = {flg_q[i], ctl_q[i], 2'b00};
            if (wb_adr_i == 8'(`TCH_ADR_CH_BASE + i * `TCH_ADR_CH_STRIDE
                + `TCH_OFS_VH))
                rbyte = val_q[i][15:8];
            if (wb_adr_i == 8'(`TCH_ADR_CH_BASE + i * `TCH_ADR_CH_STRIDE
                + `TCH_OFS_VL))
                rbyte = val_q[i][7:0];
        end
    end

    // one wait-free ack per request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {24'h000000, rbyte} : '0;
        end
    end
endmodule

// File: dv/tch_timer_assertions.sv
// checker for the timer channel block, bound to its top module
`include "tch_defs.svh"
module tch_timer_chk #(
    parameter int NCH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NCH-1:0] ch_pin_i,
    input wire logic [NCH-1:0] ch_oe_o,
    input wire logic ovf_irq_o,
    input wire logic [NCH-1:0] ch_irq_o
);
    logic take; // request accepted at this edge
    logic wr_ch; // accepted write to channel 0 control
    logic wr_tsc; // accepted write to timer status control
    logic rd_q; // last accepted request was a read
    logic [7:0] adr_q; // address of that request
    logic [7:0] ctl_q; // mirror of channel 0 control
    logic cen_q; // mirror of the center select
    logic [3:0] age_ch_q; // edges since a channel 0 control write
    logic [3:0] age_tsc_q; // edges since a status control write
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ch = take && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == `TCH_ADR_CH_BASE;
    assign wr_tsc = take && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == `TCH_ADR_TSC;
    // snoop the bus so the checker knows the channel mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= 1'b0;
            adr_q <= 8'h00;
            ctl_q <= 8'h00;
            cen_q <= 1'b0;
        end else begin
            if (take) begin
                rd_q <= !wb_we_i;
                adr_q <= wb_adr_i;
            end
            if (wr_ch) ctl_q <= wb_dat_i[7:0];
            if (wr_tsc) cen_q <= wb_dat_i[5];
        end
    end
    // saturating ages: a flag may only drop shortly after a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            age_ch_q <= 4'hF;
            age_tsc_q <= 4'hF;
        end else begin
            age_ch_q <= wr_ch ? 4'h0 : age_ch_q + {3'h0, age_ch_q != 4'hF};
            age_tsc_q <= wr_tsc ? 4'h0 :
                age_tsc_q + {3'h0, age_tsc_q != 4'hF};
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_timing_a: assert property (take |=> wb_ack_o)
        else $error("request not acknowledged on the next cycle");
    ovf_irq_on_a: assert property (wb_ack_o && rd_q &&
        adr_q == `TCH_ADR_TSC && wb_dat_o[7:6] == 2'b11 |=> ovf_irq_o)
        else $error("overflow interrupt missing while flag and enable set");
    ovf_irq_off_a: assert property (wb_ack_o && rd_q &&
        adr_q == `TCH_ADR_TSC && !wb_dat_o[6] |=> !ovf_irq_o)
        else $error("overflow interrupt raised while disabled");
    ch_irq_on_a: assert property (wb_ack_o && rd_q &&
        adr_q == `TCH_ADR_CH_BASE && wb_dat_o[7:6] == 2'b11 |=> ch_irq_o[0])
        else $error("channel interrupt missing while flag and enable set");
    ch_irq_off_a: assert property (wb_ack_o && rd_q &&
        adr_q == `TCH_ADR_CH_BASE && !wb_dat_o[6] |=> !ch_irq_o[0])
        else $error("channel interrupt raised while disabled");
    pin_drive_a: assert property ((wr_ch || wr_tsc) |-> ##2
        ch_oe_o[0] == (ctl_q[3:2] != 2'b00 && (cen_q || ctl_q[5:4] != 2'b00)))
        else $error("pin drive enable disagrees with channel mode");
    cap_rise_a: assert property ($rose(ch_pin_i[0]) && !cen_q &&
        ctl_q[6:3] == 4'b1001 |-> ##[2:6] ch_irq_o[0])
        else $error("rising capture edge did not raise channel flag");
    ch_flag_hold_a: assert property ($fell(ch_irq_o[0]) |->
        age_ch_q <= 4'h4) else $error("channel flag dropped without a write");
    ovf_flag_hold_a: assert property ($fell(ovf_irq_o) |->
        age_tsc_q <= 4'h4) else $error("overflow flag dropped without a write");
endmodule
bind tch_timer tch_timer_chk #(.NCH(NCH)) u_tch_timer_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ch_pin_i(ch_pin_i), .ch_oe_o(ch_oe_o), .ovf_irq_o(ovf_irq_o),
    .ch_irq_o(ch_irq_o)
);

// File: dv/tch_pin_model.sv
// channel pin loads and signal sources outside the timer
module tch_pin_model #(
    parameter int NCH = 2
) (
    input wire logic [NCH-1:0] drv_i, // level the timer drives
    input wire logic [NCH-1:0] oe_i, // timer owns the pin when high
    input wire logic [NCH-1:0] src_i, // level of the outside source
    output logic [NCH-1:0] lvl_o // resolved pin level
);
    // the outside source is weak, so an enabled timer driver wins
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            lvl_o[i] = oe_i[i] ? drv_i[i] : src_i[i];
        end
    end
endmodule

// File: dv/tch_testbench.sv
// self-checking bench for the timer channel block
`include "tch_defs.svh"
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("CHECK FAILED at %0t: got %0h expected %0h", \
                $time, (got), (exp)); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 2;
    localparam int MODV = 15; // short period, inside the center range
    localparam int LIMIT = 20000; // ceiling on clock cycles for the run
    localparam logic [7:0] TSC = `TCH_ADR_TSC;
    localparam logic [7:0] CH = `TCH_ADR_CH_BASE;
    localparam logic [7:0] VH = CH + `TCH_OFS_VH;
    localparam logic [7:0] VL = CH + `TCH_OFS_VL;
    localparam logic [7:0] CH1 = CH + `TCH_ADR_CH_STRIDE; // second channel
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic ovf_irq;
    logic [NCH-1:0] pin_o, pin_oe, pin_lvl, ch_irq;
    logic [NCH-1:0] src = {NCH{1'b0}}; // outside source levels
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'h8B57;
    int h;
    int per;
    logic [7:0] q;
    // center, channel control, channel value for each pwm or compare case
    int tab [13][3] = '{'{0, 8'h68, 5}, '{0, 8'h6C, 5}, '{0, 8'h68, 0},
        '{0, 8'h68, 20}, '{0, 8'h54, 7}, '{0, 8'h58, 7}, '{0, 8'h5C, 7},
        '{1, 8'h48, 3}, '{1, 8'h4C, 3}, '{1, 8'h48, 16'h8003},
        '{1, 8'h48, 20}, '{1, 8'h48, 0}, '{0, 8'h68, 1}};
    tch_timer #(.NCH(NCH)) u_tch_timer (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ch_pin_i(pin_lvl),
        .ch_pin_o(pin_o), .ch_oe_o(pin_oe), .ovf_irq_o(ovf_irq),
        .ch_irq_o(ch_irq));
    tch_pin_model #(.NCH(NCH)) u_tch_pin_model (
        .drv_i(pin_o), .oe_i(pin_oe), .src_i(src), .lvl_o(pin_lvl));
    always #10 clk_i = ~clk_i;
    // cut a hung run short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // classic single cycle; request held until the acking edge
    task automatic xfer(input logic [7:0] a, input logic w,
            input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hF, a, 24'h0, d};
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        r = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        xfer(a, 1'b0, 8'h00, r);
    endtask
    // two-step clear; the pause lets a pending edge land before arming
    task automatic clr(input logic [7:0] a, input logic [7:0] cfg);
        logic [7:0] r;
        wr(a, cfg & 8'h7F);
        repeat (8) @(posedge clk_i);
        rd(a, r);
        wr(a, cfg & 8'h7F);
    endtask
    // high cycles of channel 0 over n clocks, phase does not matter
    task automatic measure(input int n, output int hc);
        hc = 0;
        repeat (n) begin
            @(posedge clk_i);
            hc += (pin_o[0] === 1'b1);
        end
    endtask
    // reference: high cycles over two periods
    function automatic int exp_high(input int cen, input int ctl, input int v);
        int p;
        int act;
        p = cen ? 2 * MODV : MODV + 1;
        if (!cen && ctl[5:4] == 2'b01)
            return ctl[3:2] == 2'b01 ? p : (ctl[3:2] == 2'b11 ? 2 * p : 0);
        if (v == 0 || (cen && v[15])) act = 0;
        else if (v > MODV) act = p;
        else act = cen ? 2 * v : v;
        return 2 * (ctl[2] ? p - act : act);
    endfunction
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(TSC, q);
        `CHK(q, 8'h00);
        rd(8'hFC, q);
        `CHK(q, 8'h00);
        rd(CH, q);
        `CHK(q, 8'h00);
        wr(`TCH_ADR_MODH, 8'h00);
        wr(`TCH_ADR_MODL, 8'(MODV));
        wr(TSC, 8'h48);
        repeat (MODV + 4) @(posedge clk_i);
        `CHK(ovf_irq, 1'b1);
        rd(TSC, q);
        wr(TSC, 8'h40);
        rd(TSC, q);
        `CHK(q, 8'h40);
        wr(TSC, 8'h48);
        repeat (MODV + 4) @(posedge clk_i);
        rd(TSC, q);
        repeat (MODV + 4) @(posedge clk_i);
        wr(TSC, 8'h48);
        rd(TSC, q);
        `CHK(q[7], 1'b1);
        $display("test overflow done");
        tab[12][2] = 1 + ($unsigned($random(seed)) % (MODV - 1));
        for (int i = 0; i < 13; i++) begin
            per = tab[i][0] ? 2 * MODV : MODV + 1;
            wr(TSC, tab[i][0] ? 8'h68 : 8'h48);
            wr(CH, 8'(tab[i][1]));
            wr(VH, 8'(tab[i][2] >> 8));
            wr(VL, 8'(tab[i][2]));
            repeat (2 * per + 4) @(posedge clk_i);
            clr(CH, 8'(tab[i][1]));
            if (tab[i][0]) clr(TSC, 8'h68);
            measure(2 * per, h);
            `CHK(h, exp_high(tab[i][0], tab[i][1], tab[i][2]));
            if (tab[i][2] > 0 && tab[i][2] <= MODV)
                `CHK(ch_irq[0], 1'b1);
            rd(TSC, q);
            `CHK(q[7], 1'b1);
            $display("test pwm case %0d done", i);
        end
        wr(TSC, 8'h48);
        wr(CH, 8'h68);
        wr(VH, 8'h00);
        wr(VL, 8'h05);
        // edge pwm values load only at counter zero, so let one pass
        repeat (20) @(posedge clk_i);
        wr(VH, 8'h00);
        wr(CH, 8'h68);
        wr(VL, 8'h09);
        wr(`TCH_ADR_MODL, 8'h07);
        wr(TSC, 8'h48);
        wr(`TCH_ADR_MODH, 8'h00);
        repeat (40) @(posedge clk_i);
        measure(2 * (MODV + 1), h);
        `CHK(h, exp_high(0, 8'h68, 5));
        wr(VH, 8'h00);
        repeat (40) @(posedge clk_i);
        measure(2 * (MODV + 1), h);
        `CHK(h, exp_high(0, 8'h68, 9));
        $display("test byte pairing done");
        // second channel: compare, set on match, interrupt enabled
        wr(CH1, 8'h5C);
        wr(CH1 + `TCH_OFS_VH, 8'h00);
        wr(CH1 + `TCH_OFS_VL, 8'h03);
        repeat (20) @(posedge clk_i);
        `CHK({ch_irq[1], pin_oe[1], pin_o[1]}, 3'b111);
        $display("test channel one done");
        for (int c = 0; c < 4; c++) begin
            for (int e = 1; e >= 0; e--) begin
                clr(CH, 8'(8'h40 | (c << 2)));
                src[0] <= e[0];
                repeat (8) @(posedge clk_i);
                `CHK(ch_irq[0], e ? c[1] : c[0]);
            end
        end
        $display("test capture done");
        report_and_stop();
    end
endmodule
